// File: verilog/timer3_defs.svh
// Register map, field positions, reset values and clock figures of the 8-bit capture counter
`ifndef TIMER3_DEFS_SVH
`define TIMER3_DEFS_SVH

// Register indices; the Wishbone byte address is four times the index
`define T3_IDX_FIRST_DATA   6'h18
`define T3_IDX_SECOND_DATA  6'h19
`define T3_IDX_CONTROL      6'h1a
`define T3_IDX_RECEIVE      6'h26
`define T3_IDX_PIN_MUX      6'h27
`define T3_IDX_CLOCK_OPT    6'h28

// counter3_control fields
`define T3_CTL_MODE         0
`define T3_CTL_CLK_LO       1
`define T3_CTL_CLK_HI       3
`define T3_CTL_RUN          4
`define T3_CTL_AUTO_CAPTURE_ENABLE         6

// remote_receive_control fields (write side of the shared index)
`define T3_RCC_NC_LO        0
`define T3_RCC_NC_HI        4
`define T3_RCC_SCK          5
`define T3_RCC_POL          6
`define T3_RCC_EN           7

// remote_receive_status fields (read side of the shared index)
`define T3_STS_NOISE        3
`define T3_STS_OVF          4
`define T3_STS_SCK          5
`define T3_STS_POL          6
`define T3_STS_LEVEL        7

// pin_multiplex_control and clock option fields
`define T3_PMX_ES           0
`define T3_OPT_DIV          0

// Reset values
`define T3_RST_DATA         8'hff
`define T3_RST_CONTROL      8'h00
`define T3_RST_RECEIVE      8'h1f
`define T3_RST_PIN_MUX      8'h00
`define T3_RST_CLOCK_OPT    8'h00

// Clock selection figures: internal source divides by 2^(base - code), one power of two more with the clock option set
`define T3_CLK_EXTERNAL     3'h7
`define T3_PRE_BASE         4'hd
`define T3_NOISE_BASE       4'h8
`define T3_PRE_WIDTH        15

`endif

// File: verilog/timer3_pkg.sv
// Types shared by the capture counter design
package timer3_pkg;

  // Gray sequence along stop -> timer -> event -> capture
  typedef enum logic [1:0] {
    MODE_STOP    = 2'b00,
    MODE_TIMER   = 2'b01,
    MODE_EVENT   = 2'b11,
    MODE_CAPTURE = 2'b10
  } count_mode_t;

endpackage

// File: verilog/noise_filter.sv
// Noise reject front end: a level change must persist for (N-1) reject ticks
`timescale 1ns/1ps
`default_nettype none

module noise_filter
#(
  parameter int W = 5
)
(
  input  wire logic         clk_i,     // System clock
  input  wire logic         rst_i,     // Synchronous reset, active high
  input  wire logic         enable_i,  // Filter active; bypass when low
  input  wire logic         tick_i,    // Reject source clock tick
  input  wire logic [W-1:0] reject_i,  // Noise reject count field
  input  wire logic         sample_i,  // Raw level after polarity select
  output logic              level_o,   // Filtered level
  output logic              noise_o    // Pulse: a change was rejected
);

  logic [W-1:0] run_q;
  logic [W-1:0] limit;

  // Field values below the valid minimum behave as the minimum
  assign limit = (reject_i < W'(2)) ? W'(1) : reject_i - W'(1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_q   <= '0;
      level_o <= 1'b0;
      noise_o <= 1'b0;
    end
    else if (!enable_i)
    begin
      run_q   <= '0;
      level_o <= sample_i;
      noise_o <= 1'b0;
    end
    else if (sample_i == level_o)
    begin
      noise_o <= (run_q != '0);
      run_q   <= '0;
    end
    else
    begin
      noise_o <= 1'b0;
      if (tick_i)
      begin
        if (run_q + W'(1) >= limit)
        begin
          level_o <= sample_i;
          run_q   <= '0;
        end
        else
        begin
          run_q <= run_q + W'(1);
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: verilog/timer3_capture_counter.sv
// 8-bit timer, event counter and capture unit with noise-filtered input and Wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "timer3_defs.svh"

// How it works
// - Code 111 counts pin, others internal clock
// - Run bit 0 stops and clears; 1 counts
// - Auto-capture works only outside capture mode
// - Low-power stop clears run bit automatically
// - Timer mode: match interrupts, clears, continues
// - Auto-capture copies counter into second register
// - Auto-capture unsynchronised; FF and 00 unreliable
// - Event mode counts pin edge chosen by polarity
// - Event match checked only on falling edge
// - Capture mode free-runs on internal clock
// - Polarity 0: fall->second, rise->first, clear, interrupt
// - Polarity 1: rise->second, fall->first, clear, interrupt
// - First-register edge first: only first capture
// - Second register reads last capture, FF after reset
// - Pin edges pass through noise reject circuit
// - Reject time is tick period times (N-1)
// - Mode bit: 0 timer/event, 1 capture
// - Receive circuit works only when enabled
module timer3_capture_counter
  import timer3_pkg::*;
#(
  parameter int AW = 8,
  parameter int NW = 5
)
(
  input  wire logic          clk_i,              // System clock, 20 MHz
  input  wire logic          rst_i,              // Synchronous reset, active high
  input  wire logic          wb_cyc_i,           // Wishbone cycle
  input  wire logic          wb_stb_i,           // Wishbone strobe
  input  wire logic          wb_we_i,            // Wishbone write enable
  input  wire logic [AW-1:0] wb_adr_i,           // Wishbone byte address
  input  wire logic [3:0]    wb_sel_i,           // Wishbone byte selects
  input  wire logic [31:0]   wb_dat_i,           // Wishbone write data
  output logic      [31:0]   wb_dat_o,           // Wishbone read data
  output logic               wb_ack_o,           // Wishbone acknowledge
  input  wire logic          counter_input_pin_i, // External pulse input
  input  wire logic          low_power_stop_i,   // High while entering low-power stop
  output logic               counter_interrupt_o // One-cycle counter interrupt pulse
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [7:0]        control_q;
  logic [7:0]        receive_q;
  logic [7:0]        pin_mux_q;
  logic [7:0]        clock_opt_q;
  logic [7:0]        first_q;
  logic [7:0]        second_q;
  logic [7:0]        count_q;
  logic              noise_seen_q;
  count_mode_t       mode_q;
  count_mode_t       mode_d;
  logic [`T3_PRE_WIDTH-1:0] pre_q;
  logic              cnt_in_q;

  logic              run_bit;
  logic              auto_capture_enable_bit;
  logic              mode_bit;
  logic [2:0]        clk_sel;
  logic              div_opt;
  logic              es_bit;
  logic [3:0]        src_n;
  logic [3:0]        noise_n;
  logic              int_tick;
  logic              noise_tick;
  logic              raw_level;
  logic              filt_level;
  logic              noise_pulse;
  logic              cnt_in;
  logic              in_rise;
  logic              in_fall;
  logic              match_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic              req;
  logic              wr_take;
  logic              rd_take;
  logic [5:0]        idx;
  logic              wr_lane;

  assign req     = wb_cyc_i & wb_stb_i;
  assign idx     = wb_adr_i[7:2];
  assign wr_lane = wb_sel_i[0];
  // Writes and read side effects land on the edge where the master sees ack
  assign wr_take = req & wb_ack_o & wb_we_i & wr_lane;
  assign rd_take = req & wb_ack_o & ~wb_we_i;

  function automatic logic wr_hit(input logic take, input logic [5:0] a,
                                  input logic [5:0] target);
    return take && (a == target);
  endfunction

  // Pulses once every 2^n clocks from the shared prescaler
  function automatic logic div_tick(input logic [`T3_PRE_WIDTH-1:0] pre,
                                    input logic [3:0] n);
    logic [`T3_PRE_WIDTH-1:0] mask;
    mask = ~({`T3_PRE_WIDTH{1'b1}} << n);
    return &(pre | ~mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Field views

  assign run_bit  = control_q[`T3_CTL_RUN];
  assign auto_capture_enable_bit = control_q[`T3_CTL_AUTO_CAPTURE_ENABLE];
  assign mode_bit = control_q[`T3_CTL_MODE];
  assign clk_sel  = control_q[`T3_CTL_CLK_HI:`T3_CTL_CLK_LO];
  assign div_opt  = clock_opt_q[`T3_OPT_DIV];
  assign es_bit   = pin_mux_q[`T3_PMX_ES];

  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler and source ticks

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pre_q <= '0;
    else
      pre_q <= pre_q + `T3_PRE_WIDTH'(1);
  end

  assign src_n    = `T3_PRE_BASE - {1'b0, clk_sel} + {3'b000, div_opt};
  assign noise_n  = `T3_NOISE_BASE + {3'b000, div_opt};
  // Code 111 has no internal tick; its count comes from pin edges
  assign int_tick = (clk_sel != `T3_CLK_EXTERNAL) && div_tick(pre_q, src_n);
  // Borrowing the counter source leaves the filter without ticks if it is external
  assign noise_tick = receive_q[`T3_RCC_SCK] ? int_tick : div_tick(pre_q, noise_n);

  ////////////////////////////////////////////////////////////////////////////////
  // Input front end

  assign raw_level = counter_input_pin_i ^ receive_q[`T3_RCC_POL];

  noise_filter #(
    .W (NW)
  ) u_filter (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .enable_i (receive_q[`T3_RCC_EN]),
    .tick_i   (noise_tick),
    .reject_i (receive_q[`T3_RCC_NC_HI:`T3_RCC_NC_LO]),
    .sample_i (raw_level),
    .level_o  (filt_level),
    .noise_o  (noise_pulse)
  );

  // Polarity select picks which physical edge counts as rising
  assign cnt_in  = filt_level ^ es_bit;
  assign in_rise = cnt_in & ~cnt_in_q;
  assign in_fall = ~cnt_in & cnt_in_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_in_q <= 1'b0;
    else
      cnt_in_q <= cnt_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      control_q <= `T3_RST_CONTROL;
    end
    else
    begin
      if (wr_hit(wr_take, idx, `T3_IDX_CONTROL))
        control_q <= wb_dat_i[7:0];
      // Stop entry overrides a simultaneous start request
      if (low_power_stop_i)
        control_q[`T3_CTL_RUN] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      receive_q   <= `T3_RST_RECEIVE;
      pin_mux_q   <= `T3_RST_PIN_MUX;
      clock_opt_q <= `T3_RST_CLOCK_OPT;
    end
    else
    begin
      if (wr_hit(wr_take, idx, `T3_IDX_RECEIVE))
        receive_q <= wb_dat_i[7:0];
      if (wr_hit(wr_take, idx, `T3_IDX_PIN_MUX))
        pin_mux_q <= {1'b0, wb_dat_i[6:0]};
      if (wr_hit(wr_take, idx, `T3_IDX_CLOCK_OPT))
        clock_opt_q <= {7'h00, wb_dat_i[`T3_OPT_DIV]};
    end
  end

  // Set wins over the clear-on-read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      noise_seen_q <= 1'b0;
    else if (noise_pulse)
      noise_seen_q <= 1'b1;
    else if (rd_take && idx == `T3_IDX_RECEIVE)
      noise_seen_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode state

  always_comb
  begin
    if (!run_bit)
      mode_d = MODE_STOP;
    else if (mode_bit)
      mode_d = MODE_CAPTURE;
    else if (clk_sel == `T3_CLK_EXTERNAL)
      mode_d = MODE_EVENT;
    else
      mode_d = MODE_TIMER;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode_q <= MODE_STOP;
    else
      mode_q <= mode_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter and interrupt

  assign match_next = (count_q + 8'h01) == first_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_q             <= 8'h00;
      counter_interrupt_o <= 1'b0;
    end
    else
    begin
      counter_interrupt_o <= 1'b0;
      case (mode_q)
        MODE_STOP:
        begin
          count_q <= 8'h00;
        end
        MODE_TIMER:
        begin
          if (int_tick)
          begin
            if (match_next)
            begin
              count_q             <= 8'h00;
              counter_interrupt_o <= 1'b1;
            end
            else
            begin
              count_q <= count_q + 8'h01;
            end
          end
        end
        MODE_EVENT:
        begin
          if (in_rise)
            count_q <= count_q + 8'h01;
          else if (in_fall && count_q == first_q)
          begin
            count_q             <= 8'h00;
            counter_interrupt_o <= 1'b1;
          end
        end
        MODE_CAPTURE:
        begin
          if (in_rise)
          begin
            count_q             <= 8'h00;
            counter_interrupt_o <= 1'b1;
          end
          else if (int_tick)
          begin
            count_q <= count_q + 8'h01;
          end
        end
        default:
        begin
          count_q <= 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data registers

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      first_q <= `T3_RST_DATA;
    else if (mode_q == MODE_CAPTURE && in_rise)
      first_q <= count_q;
    else if (wr_hit(wr_take, idx, `T3_IDX_FIRST_DATA))
      first_q <= wb_dat_i[7:0];
  end

  // A first-register edge never touches this register, so an opening such
  // edge leaves the previous capture (or the reset value) in place
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      second_q <= `T3_RST_DATA;
    else if (mode_q == MODE_CAPTURE && in_fall)
      second_q <= count_q;
    else if ((mode_q == MODE_TIMER || mode_q == MODE_EVENT) && auto_capture_enable_bit)
      // Free copy every clock; a read landing on a wrap may see FF or 00 stale
      second_q <= count_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answer

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req & ~wb_ack_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (req && !wb_ack_o)
    begin
      wb_dat_o <= 32'h0000_0000;
      // Control and multiplex registers are write-only and read as zero
      if (idx == `T3_IDX_FIRST_DATA)
        wb_dat_o[7:0] <= first_q;
      else if (idx == `T3_IDX_SECOND_DATA)
        wb_dat_o[7:0] <= second_q;
      else if (idx == `T3_IDX_RECEIVE)
      begin
        wb_dat_o[`T3_STS_LEVEL] <= filt_level;
        wb_dat_o[`T3_STS_POL]   <= receive_q[`T3_RCC_POL];
        wb_dat_o[`T3_STS_SCK]   <= receive_q[`T3_RCC_SCK];
        wb_dat_o[`T3_STS_OVF]   <= 1'b0;
        wb_dat_o[`T3_STS_NOISE] <= noise_seen_q;
      end
      else if (idx == `T3_IDX_CLOCK_OPT)
        wb_dat_o[7:0] <= clock_opt_q;
    end
  end

endmodule
`default_nettype wire

// File: test/timer3_capture_counter_properties.sv
// Port-level assertions and covers of the capture counter, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "timer3_defs.svh"

module timer3_checker
  import timer3_pkg::*;
#(
  parameter int AW = 8,
  parameter int NW = 5
)
(
  input wire logic          clk_i,               // Clock
  input wire logic          rst_i,               // Reset
  input wire logic          wb_cyc_i,            // Cycle
  input wire logic          wb_stb_i,            // Strobe
  input wire logic          wb_we_i,             // Write
  input wire logic [AW-1:0] wb_adr_i,            // Address
  input wire logic [3:0]    wb_sel_i,            // Selects
  input wire logic [31:0]   wb_dat_i,            // Write data
  input wire logic [31:0]   wb_dat_o,            // Read data
  input wire logic          wb_ack_o,            // Acknowledge
  input wire logic          counter_input_pin_i, // Pin
  input wire logic          low_power_stop_i,    // Stop request
  input wire logic          counter_interrupt_o  // Interrupt
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [5:0] idx;
  logic       rd_ack;
  assign idx = wb_adr_i[7:2];
  assign rd_ack = wb_ack_o && !wb_we_i;

  ////////////////////////////////////////////////////////////////////////////////
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_ctl_write_only: assert property (rd_ack && idx == `T3_IDX_CONTROL |-> wb_dat_o == 0)
    else $error("control register readable");
  a_mux_write_only: assert property (rd_ack && idx == `T3_IDX_PIN_MUX |-> wb_dat_o == 0)
    else $error("multiplex register readable");
  a_unmapped_reads_zero: assert property (rd_ack && idx == 6'h00 |-> wb_dat_o == 0)
    else $error("unmapped read not zero");
  a_high_lanes_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  a_irq_one_pulse: assert property (counter_interrupt_o |=> !counter_interrupt_o)
    else $error("interrupt longer than one cycle");
  a_stop_halts_irq: assert property (low_power_stop_i [*4] |-> !counter_interrupt_o)
    else $error("interrupt during low-power stop");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !counter_interrupt_o)
    else $error("outputs active after reset");

  c_irq: cover property (counter_interrupt_o);
  c_second_read: cover property (rd_ack && idx == `T3_IDX_SECOND_DATA);
  c_stop: cover property (low_power_stop_i [*4]);
endmodule

bind timer3_capture_counter timer3_checker #(.AW(AW), .NW(NW)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .counter_input_pin_i(counter_input_pin_i),
  .low_power_stop_i(low_power_stop_i), .counter_interrupt_o(counter_interrupt_o));
`default_nettype wire

// File: test/pulse_source.sv
// External pulse source on the counter input pin
`timescale 1ns/1ps
`default_nettype none

module pulse_source
(
  input  wire logic        clk_i,      // System clock
  input  wire logic        rst_i,      // Reset
  input  wire logic        start_i,    // Begin one pulse
  input  wire logic [15:0] high_len_i, // High cycles
  input  wire logic [15:0] low_len_i,  // Low cycles after
  output logic             pin_o,      // Pin level
  output logic             busy_o      // Pulse in progress
);
  logic [16:0] cnt_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_q <= 17'h0_0000;
    else if (start_i && cnt_q == 0)
      cnt_q <= {1'b0, high_len_i} + {1'b0, low_len_i};
    else if (cnt_q != 0)
      cnt_q <= cnt_q - 1;
  end

  // Caller sizes both phases to one source clock or more
  assign pin_o = cnt_q > {1'b0, low_len_i};
  assign busy_o = cnt_q != 0;
endmodule
`default_nettype wire

// File: test/timer3_capture_counter_tb.sv
// Self-checking bench of the capture counter: registers, capture, timer and event modes
`timescale 1ns/1ps
`default_nettype none
`include "timer3_defs.svh"

module timer3_capture_counter_tb;
  import timer3_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [3:0]  wb_sel = 4'hf;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        irq;
  logic        lp_stop = 1'b0;
  logic        p_start = 1'b0;
  logic [15:0] p_high = 16'h0001;
  logic [15:0] p_low = 16'h0001;
  logic        pin;
  logic        p_busy;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc_cnt = 0;
  int          irq_cnt = 0;
  int          t0;
  int          b;
  logic [31:0] rd;
  logic [31:0] cap;
  logic [7:0]  cmp;

  initial forever #25 clk_i = ~clk_i;

  timer3_capture_counter dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .counter_input_pin_i(pin), .low_power_stop_i(lp_stop),
    .counter_interrupt_o(irq));

  pulse_source src_u (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(p_start), .high_len_i(p_high),
    .low_len_i(p_low), .pin_o(pin), .busy_o(p_busy));

  // Updated late so that waits on the same edge see a consistent count
  always @(posedge clk_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (irq === 1'b1)
      irq_cnt <= irq_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic give_up();
    error_cnt++;
    $display("mismatch at %0t: wait ran out", $time);
    complete_run();
  endtask

  // One classic cycle; entered just after a rising edge
  task automatic wb_io(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int k;
    wb_cyc <= 1'b1;
    wb_we <= w;
    wb_adr <= {idx, 2'b00};
    wb_wdat <= {24'h00_0000, d};
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end while (wb_ack !== 1'b1 && k < 20);
    if (k >= 20)
      give_up();
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_irq(input int n);
    int k;
    k = 0;
    while (irq_cnt < n && k < 20000)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 20000)
      give_up();
  endtask

  task automatic launch(input int h, input int l);
    p_high <= 16'(h);
    p_low <= 16'(l);
    p_start <= 1'b1;
    @(posedge clk_i);
    p_start <= 1'b0;
  endtask

  task automatic finish_pulse();
    int k;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end while (p_busy === 1'b1 && k < 10000);
    if (k >= 10000)
      give_up();
  endtask

  function automatic logic [7:0] ctl(input logic auto_capture_enable, input logic run, input logic [2:0] code,
                                     input logic mode);
    return {1'b0, auto_capture_enable, 1'b0, run, code, mode};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(75286));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // A write without the low byte lane must leave the register alone
    wb_sel <= 4'he;
    wb_io(1, `T3_IDX_FIRST_DATA, 8'h33);
    wb_sel <= 4'hf;
    wb_io(0, `T3_IDX_FIRST_DATA, 0);
    check(rd, 32'h0000_00ff);
    wb_io(0, `T3_IDX_SECOND_DATA, 0);
    check(rd, 32'h0000_00ff);
    wb_io(1, 6'h00, 8'h5a);
    wb_io(0, 6'h00, 0);
    check(rd, 32'h0000_0000);
    wb_io(1, `T3_IDX_CONTROL, ctl(1, 0, 3'h6, 1));
    wb_io(0, `T3_IDX_CONTROL, 0);
    check(rd, 32'h0000_0000);
    wb_io(1, `T3_IDX_PIN_MUX, 8'h01);
    wb_io(0, `T3_IDX_PIN_MUX, 0);
    check(rd, 32'h0000_0000);
    wb_io(1, `T3_IDX_PIN_MUX, 8'h00);
    $display("test registers done");

    // Capture: filter on, reject time 3 ticks of 256 clocks
    wb_io(1, `T3_IDX_RECEIVE, 8'h84);
    wb_io(1, `T3_IDX_CONTROL, ctl(0, 1, 3'h6, 1));
    // Long enough to span one or two reject ticks, never three
    launch(300, 1200);
    finish_pulse();
    check(irq_cnt, 0);
    wb_io(0, `T3_IDX_RECEIVE, 0);
    check(rd[`T3_STS_NOISE], 1'b1);
    wb_io(0, `T3_IDX_RECEIVE, 0);
    check(rd[`T3_STS_NOISE], 1'b0);
    launch(1280, 1500);
    wait_irq(1);
    wb_io(0, `T3_IDX_SECOND_DATA, 0);
    check(rd, 32'h0000_00ff);
    finish_pulse();
    wb_io(0, `T3_IDX_SECOND_DATA, 0);
    check(rd >= 8 && rd <= 12, 1);
    launch(1280, 1500);
    wait_irq(2);
    wb_io(0, `T3_IDX_FIRST_DATA, 0);
    check(rd >= 18 && rd <= 25, 1);
    finish_pulse();
    wb_io(1, `T3_IDX_CONTROL, ctl(0, 0, 3'h6, 1));
    $display("test capture done");

    // Timer periods at both divider settings, auto-capture on
    for (int div = 0; div < 2; div++)
    begin
      wb_io(1, `T3_IDX_CONTROL, ctl(1, 0, 3'h6, 0));
      cmp = 8'(2 + $urandom_range(3));
      wb_io(1, `T3_IDX_CLOCK_OPT, 8'(div));
      wb_io(1, `T3_IDX_FIRST_DATA, cmp);
      wb_io(1, `T3_IDX_CONTROL, ctl(1, 1, 3'h6, 0));
      b = irq_cnt;
      wait_irq(b + 1);
      t0 = cyc_cnt;
      wait_irq(b + 2);
      check(cyc_cnt - t0, cmp * (128 << div));
      wb_io(0, `T3_IDX_SECOND_DATA, 0);
      check(rd < cmp, 1);
    end
    lp_stop <= 1'b1;
    repeat (4) @(posedge clk_i);
    lp_stop <= 1'b0;
    b = irq_cnt;
    repeat (cmp * 512) @(posedge clk_i);
    check(irq_cnt, b);
    t0 = cyc_cnt;
    wb_io(1, `T3_IDX_CONTROL, ctl(0, 1, 3'h6, 0));
    wait_irq(b + 1);
    check(cyc_cnt - t0 > (cmp - 1) * 256 && cyc_cnt - t0 <= cmp * 256 + 8, 1);
    wb_io(1, `T3_IDX_CONTROL, ctl(0, 0, 3'h6, 0));
    $display("test timer done");

    // Event counting on the pin, filter bypassed, both polarities
    wb_io(1, `T3_IDX_RECEIVE, 8'h1f);
    wb_io(1, `T3_IDX_CONTROL, ctl(0, 0, 3'h7, 0));
    for (int pol = 0; pol < 2; pol++)
    begin
      wb_io(1, `T3_IDX_PIN_MUX, 8'(pol));
      wb_io(1, `T3_IDX_CONTROL, ctl(0, 1, 3'h7, 0));
      b = irq_cnt;
      repeat (2 * cmp + 1)
      begin
        launch(4, 4);
        finish_pulse();
      end
      repeat (4) @(posedge clk_i);
      check(irq_cnt - b, 2);
      wb_io(1, `T3_IDX_CONTROL, ctl(0, 0, 3'h7, 0));
    end
    $display("test event done");

    // Reset with the counter stopped brings the captured value back to its reset state
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb_io(0, `T3_IDX_SECOND_DATA, 0);
    check(rd, 32'h0000_00ff);
    wb_io(0, `T3_IDX_RECEIVE, 0);
    check(rd, 32'h0000_0000);
    $display("test reset done");
    complete_run();
  end
endmodule
`default_nettype wire
